// ===== bench/ptk_top_monitor.sv
// Port checker of the tick, thermal restart and reset-status block
`timescale 1ns/1ps
module ptk_mon (
  input wire        core_clk_i,     // Core clock
  input wire        rst_n_i,        // Synchronous reset, active low
  input wire        psel,           // APB select
  input wire        penable,        // APB enable
  input wire        pwrite,         // APB direction
  input wire [15:0] paddr,          // APB address
  input wire [31:0] pwdata,         // APB write data
  input wire [31:0] prdata,         // APB read data
  input wire        pready,         // APB ready
  input wire        pslverr,        // APB error
  input wire        converter_en_i, // Converter enabled
  input wire        tick_irq_o,     // Tick request
  input wire        tick_wake_o,    // Tick wake-up
  input wire        sensor_power_o, // Sensor power
  input wire        wdog_restart_o, // Watchdog restart pulse
  input wire        slow_osc_on_o   // Slow oscillator request
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Setup cycle, and an access completing
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_unmapped_error: assert property ((psel && !penable && paddr == 16'h1810) |=> pslverr)
    else $error("unmapped access without error");
  a_ack_reads_zero: assert property ((s_done ##0 (!pwrite && paddr == 16'h1808)) |->
    (prdata[6] == 1'b0 && prdata[3] == 1'b0 && prdata[31:8] == 24'h0)) else $error("tick ctl zero bits set");
  a_status_bit_zero: assert property ((s_done ##0 (!pwrite && paddr == 16'h1800)) |->
    prdata[0] == 1'b0) else $error("status bit 0 set");
  a_write_kicks_wdog: assert property ((s_done ##0 (pwrite && paddr == 16'h1800)) |->
    ##[1:2] wdog_restart_o) else $error("no watchdog restart");
  a_kick_one_cycle: assert property (wdog_restart_o |=> !wdog_restart_o) else $error("restart too long");
  a_irq_masked: assert property ((s_done ##0 (pwrite && paddr == 16'h1808 && !pwdata[4])) |->
    ##2 !tick_irq_o) else $error("request not masked");
  a_wake_needs_irq: assert property (tick_wake_o |-> tick_irq_o) else $error("wake without request");
  a_sensor_follows: assert property ($past(rst_n_i) |-> sensor_power_o == $past(converter_en_i))
    else $error("sensor power wrong");
  a_slow_osc_on: assert property (slow_osc_on_o) else $error("slow oscillator off");
endmodule
bind ptk_top ptk_mon i_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .converter_en_i(converter_en_i), .tick_irq_o(tick_irq_o), .tick_wake_o(tick_wake_o),
  .sensor_power_o(sensor_power_o), .wdog_restart_o(wdog_restart_o), .slow_osc_on_o(slow_osc_on_o));

// ===== bench/ptk_top_tb_top.sv
// Self-checking bench of the tick, thermal restart and reset-status block
`timescale 1ns/1ps
module ptk_top_tb_top;
  logic        core_clk_i = 0, rst_n_i = 0;                   // Clock and reset
  logic        psel = 0, penable = 0, pwrite = 0;             // APB control
  logic [15:0] paddr = 0;                                     // APB address
  logic [31:0] pwdata = 0;                                    // APB write data
  wire  [31:0] prdata;                                        // APB read data
  wire         pready, pslverr;                               // APB answer
  logic        slow_osc_i = 0, fast_osc_i = 0, run_mode_i = 1, low_power_i = 0, deep_stop_i = 0;
  logic        cause_por_i = 0, cause_pin_i = 0, cause_wdog_i = 0, cause_badop_i = 0;
  logic        cause_badad_i = 0, cause_wut_i = 0, cause_lvd_i = 0, debug_force_reset_i = 0;
  logic        temp_back_low_i = 0, temp_back_high_i = 0, converter_en_i = 0;
  wire         tick_irq_o, tick_wake_o, thermal_wake_o, sensor_power_o, wdog_restart_o, wdog_enable_o, slow_osc_on_o;
  logic [4:0]  sc = 0;                                        // Oscillator divider
  int          mismatches = 0, compares = 0, n, k;            // Counters
  logic [31:0] q;                                             // Read data
  logic        e;                                             // Read error
  logic [6:0]  rc [6] = '{7'h40, 7'h01, 7'h43, 7'h3C, 7'h20, 7'h3C}; // Reset causes
  logic [7:0]  rx [6] = '{8'h82, 8'h82, 8'h82, 8'h78, 8'h00, 8'h00}; // Expected status

  ptk_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_i(slow_osc_i), .fast_osc_i(fast_osc_i), .run_mode_i(run_mode_i), .low_power_i(low_power_i),
    .deep_stop_i(deep_stop_i), .cause_por_i(cause_por_i), .cause_lvd_i(cause_lvd_i), .cause_pin_i(cause_pin_i),
    .cause_wdog_i(cause_wdog_i), .cause_badop_i(cause_badop_i), .cause_badad_i(cause_badad_i),
    .cause_wut_i(cause_wut_i), .debug_force_reset_i(debug_force_reset_i), .temp_back_low_i(temp_back_low_i),
    .temp_back_high_i(temp_back_high_i), .converter_en_i(converter_en_i), .tick_irq_o(tick_irq_o),
    .tick_wake_o(tick_wake_o), .thermal_wake_o(thermal_wake_o), .sensor_power_o(sensor_power_o),
    .wdog_restart_o(wdog_restart_o), .wdog_enable_o(wdog_enable_o), .slow_osc_on_o(slow_osc_on_o));

  always #5 core_clk_i = ~core_clk_i;
  // Sped-up slow oscillator (20 cycles) and fast one (4 cycles)
  always @(posedge core_clk_i) begin
    sc <= (sc == 5'h13) ? 5'h00 : sc + 5'h01;
    if (sc == 5'h09 || sc == 5'h13) slow_osc_i <= ~slow_osc_i;
    if (sc[0]) fast_osc_i <= ~fast_osc_i;
  end

  // Compare and count
  task automatic chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input w, input [15:0] a, input [31:0] d, output [31:0] rq, output re);
    int t;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge core_clk_i); t++; end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) mismatches++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input [15:0] a, input [31:0] d); apb(1'b1, a, d, q, e); endtask
  task automatic rd(input [15:0] a, input [31:0] x); apb(1'b0, a, 32'h0, q, e); chk(q, x); endtask
  // Reset with the given causes held throughout
  task automatic do_rst(input [6:0] c, input dbg, input ds);
    {cause_por_i, cause_pin_i, cause_wdog_i, cause_badop_i, cause_badad_i, cause_wut_i, cause_lvd_i} <= c;
    debug_force_reset_i <= dbg; deep_stop_i <= ds; rst_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1; deep_stop_i <= 1'b0; debug_force_reset_i <= 1'b0;
    {cause_por_i, cause_pin_i, cause_wdog_i, cause_badop_i, cause_badad_i, cause_wut_i, cause_lvd_i} <= 7'h00;
    @(posedge core_clk_i);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge core_clk_i);
    mismatches++;
    end_of_test;
  end

  initial begin
    do_rst(7'h40, 1'b0, 1'b0);
    rd(16'h1800, 32'h82);
    rd(16'h1808, 32'h00);
    rd(16'h180C, 32'h01);
    wr(16'h1800, 32'hFF);
    rd(16'h1800, 32'h82);
    apb(1'b0, 16'h1810, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(16'h1808, 32'hFF);
    rd(16'h1808, 32'h37);
    // Each period code 1..7 counted in slow edges
    for (k = 1; k < 8; k++) begin
      @(posedge slow_osc_i); repeat (8) @(posedge core_clk_i);
      wr(16'h1808, 32'h50 | k);
      n = 0; q = 0;
      while (q[7] !== 1'b1 && n < 300) begin
        @(posedge slow_osc_i); repeat (8) @(posedge core_clk_i);
        apb(1'b0, 16'h1808, 32'h0, q, e); n++;
      end
      chk(n, 1 << k);
      chk(q, 32'h90 | k);
      chk(tick_irq_o, 1);
    end
    wr(16'h1808, 32'h41);
    repeat (3) @(posedge slow_osc_i);
    rd(16'h1808, 32'h81);
    chk(tick_irq_o, 0);
    wr(16'h1808, 32'h11);
    rd(16'h1808, 32'h91);
    chk(tick_irq_o, 1);
    low_power_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(tick_wake_o, 1);
    low_power_i <= 1'b0;
    wr(16'h1808, 32'h40);
    repeat (6) @(posedge slow_osc_i);
    rd(16'h1808, 32'h00);
    run_mode_i <= 1'b0;
    wr(16'h1808, 32'h61);
    repeat (6) @(posedge slow_osc_i);
    rd(16'h1808, 32'h21);
    run_mode_i <= 1'b1;
    // Thermal restart from deepest stop
    converter_en_i <= 1'b1;
    wr(16'h1804, 32'h8C);
    rd(16'h1804, 32'h8D);
    deep_stop_i <= 1'b1;
    temp_back_high_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk({sensor_power_o, wdog_enable_o, thermal_wake_o}, 3'b111);
    temp_back_high_i <= 1'b0; temp_back_low_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(thermal_wake_o, 0);
    wr(16'h1804, 32'h84);
    rd(16'h1804, 32'h85);
    temp_back_high_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(thermal_wake_o, 0);
    temp_back_high_i <= 1'b0; temp_back_low_i <= 1'b0; deep_stop_i <= 1'b0;
    // Reset causes: power-on, low voltage, others, pin in stop, debug
    for (k = 0; k < 6; k++) begin
      do_rst(rc[k], k == 5, k == 4);
      rd(16'h1800, {24'h0, rx[k]});
      rd(16'h1808, 32'h00);
    end
    end_of_test;
  end
endmodule

// ===== verilog/ptk_defs.vh
// Register offsets, field positions, reset values and timing counts of the tick and reset-status block
`ifndef PTK_DEFS_VH
`define PTK_DEFS_VH
`define PTK_OFS_RSTAT        16'h1800
`define PTK_OFS_TICK         16'h1808
`define PTK_OFS_SYSOPT       16'h1804
`define PTK_OFS_MODE         16'h180C
`define PTK_TICK_RST         8'h00
`define PTK_BIT_FLAG         7
`define PTK_BIT_ACK          6
`define PTK_BIT_CLKS         5
`define PTK_BIT_IE           4
`define PTK_RS_POR           7
`define PTK_RS_PIN           6
`define PTK_RS_WDOG          5
`define PTK_RS_BADOP         4
`define PTK_RS_BADAD         3
`define PTK_RS_WUT           2
`define PTK_RS_LVD           1
`define PTK_BIT_WDE          7
`define PTK_BIT_TRE          3
`define PTK_BIT_TRH          2
`define PTK_SYSOPT_RST       8'h81
`define PTK_CLK_MHZ          100
`define PTK_SLOW_MS          1
`define PTK_FAST_KHZ         8000
`define PTK_FAST_PER_MS      (`PTK_FAST_KHZ * `PTK_SLOW_MS)
`define PTK_FAST_LAST        14'h1F3F
`endif

// ===== verilog/ptk_div.v
// Tick divider: counts source-clock ticks up to the selected period
`timescale 1ns/1ps
module ptk_div (
  input  wire        core_clk_i,  // Core clock
  input  wire        rst_n_i,     // Synchronous reset, active low
  input  wire        restart_i,   // Restart from zero
  input  wire        step_i,      // One source-clock millisecond step
  input  wire [2:0]  period_i,    // Period code
  output reg         tick_o       // One-cycle tick pulse
);
  reg  [7:0] cnt_r;               // Milliseconds elapsed
  wire [7:0] limit;               // Milliseconds per tick minus one

  // Code n of 1..7 gives 2^n ms
  assign limit = (8'h01 << period_i) - 8'h01;

  // Count steps, tick at the limit
  always @(posedge core_clk_i) begin
    if (!rst_n_i || restart_i || period_i == 3'h0) begin
      cnt_r  <= 8'h00;
      tick_o <= 1'b0;
    end else if (step_i) begin
      if (cnt_r == limit) begin
        cnt_r  <= 8'h00;
        tick_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 8'h01;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== verilog/ptk_edge.v
// Rising-edge detector for one synchronous strobe input
`timescale 1ns/1ps
module ptk_edge (
  input  wire core_clk_i,   // Core clock
  input  wire rst_n_i,      // Synchronous reset, active low
  input  wire level_i,      // Level to watch
  output reg  rise_o        // One-cycle pulse on rising edge
);
  reg level_r;              // Previous level

  // Remember level and flag a 0 to 1 change
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      level_r <= level_i;   // Start from the pin's level, so no false edge after reset
      rise_o  <= 1'b0;
    end else begin
      level_r <= level_i;
      rise_o  <= level_i & ~level_r;
    end
  end
endmodule

// ===== verilog/ptk_top.v
// Periodic tick, thermal restart control and reset-source status with APB access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "ptk_defs.vh"
// Operation
// - Clock select: 0 slow, 1 fast oscillator
// - Period code 0 off, 1..7 2..128 ms
// - Flag sticks until acknowledge written one
// - Acknowledge reads zero, zero write harmless
// - Interrupt enable gates request, not flag
// - Tick also wakes from low power
// - Slow oscillator always runs, no control
// - Reset clears tick control; bit3 zero
// - Thermal detector wakes deepest stop via reset
// - Enable gates restart; level picks direction
// - Sensor powered whenever converter enabled
// - Seven read-only reset flags; bit0 zero
// - Debug forced reset clears all flags
// - Any status write restarts the watchdog
// - Other resets latch active sources only
// - Power-on or low voltage sets bits 7,1
// - Pin flag records pin reset outside deepest stop
// - Watchdog flag; source gated by enable, which reset sets to one
// - Bad opcode flag in bit 4
// - Wake-up timer flag in bit 2
module ptk_top (
  input  wire        core_clk_i,        // Core clock, 100 MHz
  input  wire        rst_n_i,           // Synchronous reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB enable
  input  wire        pwrite,            // APB direction
  input  wire [15:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output reg  [31:0] prdata,            // APB read data
  output reg         pready,            // APB ready
  output reg         pslverr,           // APB error
  input  wire        slow_osc_i,        // Slow always-on oscillator (1 kHz)
  input  wire        fast_osc_i,        // Fast oscillator (8 MHz)
  input  wire        run_mode_i,        // Processor in run mode
  input  wire        low_power_i,       // Processor in any low-power mode
  input  wire        deep_stop_i,       // Processor in deepest stop mode
  input  wire        cause_por_i,       // Power-on reset cause
  input  wire        cause_lvd_i,       // Low-voltage reset cause
  input  wire        cause_pin_i,       // Reset pin cause
  input  wire        cause_wdog_i,      // Watchdog timeout cause
  input  wire        cause_badop_i,     // Bad opcode cause
  input  wire        cause_badad_i,     // Bad address cause
  input  wire        cause_wut_i,       // Wake-up timer cause
  input  wire        debug_force_reset_i, // Debug host forced reset
  input  wire        temp_back_low_i,   // Temperature back from very low
  input  wire        temp_back_high_i,  // Temperature back from very high
  input  wire        converter_en_i,    // Analog converter enabled
  output reg         tick_irq_o,        // Tick interrupt request
  output reg         tick_wake_o,       // Tick wake-up request
  output reg         thermal_wake_o,    // Thermal restart wake-up (leads to reset)
  output reg         sensor_power_o,    // Accurate sensor power, channel 1
  output reg         wdog_restart_o,    // Watchdog restart pulse
  output reg         wdog_enable_o,     // Watchdog enable
  output reg         slow_osc_on_o      // Slow oscillator power request
);
  reg  [7:0] rstat_r;                   // Reset-source flags
  reg        flag_r;                    // Tick flag
  reg        clks_r;                    // Tick clock select
  reg        ie_r;                      // Tick interrupt enable
  reg  [2:0] per_r;                     // Tick period code
  reg        tre_r;                     // Thermal restart enable
  reg        trh_r;                     // Thermal restart level
  reg        wde_r;                     // Watchdog enable
  reg        wde_done_r;                // Watchdog enable write-once
  reg  [13:0] fast_cnt_r;               // Fast-clock edges per ms
  reg        ms_fast_r;                 // Millisecond step from fast clock
  reg        held_r;                    // Reset was active last cycle
  wire       slow_rise;                 // Slow oscillator edge
  wire       fast_rise;                 // Fast oscillator edge
  wire       step;                      // Selected millisecond step
  wire       tick;                      // Tick event
  wire       wr;                        // APB write access
  wire       rd;                        // APB read access
  wire       hit_rs;                    // Status address
  wire       hit_tk;                    // Tick control address
  wire       hit_so;                    // System option address
  wire       hit_md;                    // Mode view address
  wire       per_wr;                    // Period field written
  wire       ack;                       // Acknowledge write
  wire [7:0] tick_view;                 // Tick register read value
  wire [7:0] sysopt_view;               // System option read value

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign hit_rs = paddr == `PTK_OFS_RSTAT;
  assign hit_tk = paddr == `PTK_OFS_TICK;
  assign hit_so = paddr == `PTK_OFS_SYSOPT;
  assign hit_md = paddr == `PTK_OFS_MODE;
  assign per_wr = wr & hit_tk;
  assign ack    = wr & hit_tk & pwdata[`PTK_BIT_ACK];
  assign tick_view   = {flag_r, 1'b0, clks_r, ie_r, 1'b0, per_r};
  assign sysopt_view = {wde_r, 3'h0, tre_r, trh_r, 2'h1};

  // Edge detectors for the two oscillator inputs
  ptk_edge u_slow (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .level_i    (slow_osc_i),
    .rise_o     (slow_rise)
  );
  ptk_edge u_fast (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .level_i    (fast_osc_i),
    .rise_o     (fast_rise)
  );

  // Scale the fast clock to millisecond steps
  always @(posedge core_clk_i) begin
    if (!rst_n_i || !clks_r) begin
      fast_cnt_r <= 14'h0000;
      ms_fast_r  <= 1'b0;
    end else if (fast_rise) begin
      if (fast_cnt_r == `PTK_FAST_LAST) begin
        fast_cnt_r <= 14'h0000;
        ms_fast_r  <= 1'b1;
      end else begin
        fast_cnt_r <= fast_cnt_r + 14'h0001;
        ms_fast_r  <= 1'b0;
      end
    end else begin
      ms_fast_r <= 1'b0;
    end
  end

  // Fast source only counts in run mode
  assign step = clks_r ? (ms_fast_r & run_mode_i) : slow_rise;

  // Tick period divider
  ptk_div u_div (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .restart_i  (per_wr),
    .step_i     (step),
    .period_i   (per_r),
    .tick_o     (tick)
  );

  // Tick control register and sticky flag
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'b0;
      clks_r <= 1'b0;
      ie_r   <= 1'b0;
      per_r  <= 3'h0;
    end else begin
      if (tick) begin
        flag_r <= 1'b1;
      end else if (ack) begin
        flag_r <= 1'b0;
      end
      if (per_wr) begin
        clks_r <= pwdata[`PTK_BIT_CLKS];
        ie_r   <= pwdata[`PTK_BIT_IE];
        per_r  <= pwdata[2:0];
      end
    end
  end

  // System option bits: watchdog enable write-once, thermal restart
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wde_r      <= 1'b1;
      wde_done_r <= 1'b0;
      tre_r      <= 1'b0;
      trh_r      <= 1'b0;
    end else if (wr && hit_so) begin
      tre_r <= pwdata[`PTK_BIT_TRE];
      trh_r <= pwdata[`PTK_BIT_TRH];
      if (!wde_done_r) begin
        wde_r      <= pwdata[`PTK_BIT_WDE];
        wde_done_r <= 1'b1;
      end
    end
  end

  // Reset-source flags captured while reset is held; wake-up timer flag set in the first cycle after release
  always @(posedge core_clk_i) begin
    held_r <= ~rst_n_i;
    if (!rst_n_i) begin
      if (debug_force_reset_i) begin
        rstat_r <= 8'h00;
      end else if (cause_por_i || cause_lvd_i) begin
        rstat_r <= 8'h82;
      end else begin
        rstat_r <= 8'h00;
        rstat_r[`PTK_RS_PIN]   <= cause_pin_i & ~deep_stop_i;
        rstat_r[`PTK_RS_WDOG]  <= cause_wdog_i & wde_r;
        rstat_r[`PTK_RS_BADOP] <= cause_badop_i;
        rstat_r[`PTK_RS_BADAD] <= cause_badad_i;
        rstat_r[`PTK_RS_WUT]   <= 1'b0;
      end
    end else if (held_r && cause_wut_i && !cause_por_i && !cause_lvd_i && !deep_stop_i) begin
      rstat_r[`PTK_RS_WUT] <= 1'b1;
    end
  end

  // APB slave: zero-wait answer, unmapped reads zero with error
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_rs | hit_tk | hit_so | hit_md);
      if (psel && !penable && !pwrite) begin
        if (hit_rs) begin
          prdata <= {24'h000000, rstat_r[7:1], 1'b0};
        end else if (hit_tk) begin
          prdata <= {24'h000000, tick_view};
        end else if (hit_so) begin
          prdata <= {24'h000000, sysopt_view};
        end else if (hit_md) begin
          prdata <= {29'h00000000, deep_stop_i, low_power_i, run_mode_i};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Outputs: interrupt, wake-ups, watchdog, power
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tick_irq_o     <= 1'b0;
      tick_wake_o    <= 1'b0;
      thermal_wake_o <= 1'b0;
      sensor_power_o <= 1'b0;
      wdog_restart_o <= 1'b0;
      wdog_enable_o  <= 1'b1;
      slow_osc_on_o  <= 1'b1;
    end else begin
      tick_irq_o     <= flag_r & ie_r & ~ack;
      tick_wake_o    <= flag_r & ie_r & low_power_i & ~ack;
      thermal_wake_o <= tre_r & deep_stop_i &
                        (trh_r ? temp_back_high_i : temp_back_low_i);
      sensor_power_o <= converter_en_i;
      wdog_restart_o <= wr & hit_rs;
      wdog_enable_o  <= wde_r;
      slow_osc_on_o  <= 1'b1;
    end
  end
endmodule
